// >>> verilog/cpwm_defines.vh
`ifndef CPWM_DEFINES_VH
`define CPWM_DEFINES_VH

// register indices; byte address is four times the index
`define CPWM_IDX_PORT_DATA    6'h07
`define CPWM_IDX_TIMER        6'h11
`define CPWM_IDX_TIMER_CTRL   6'h12
`define CPWM_IDX_PERIOD       6'h13
`define CPWM_IDX_PORT_DIR     6'h14
`define CPWM_IDX_DUTY_WRITE   6'h15
`define CPWM_IDX_DUTY_SHADOW  6'h16
`define CPWM_IDX_UNIT_CTRL    6'h17
`define CPWM_IDX_STATUS       6'h18
`define CPWM_IDX_UNIT2_CTRL   6'h1d

// control register fields
`define CPWM_CTRL_DUTY_LSB    5:4
`define CPWM_CTRL_MODE        3:0
`define CPWM_CTRL_PWM_BITS    3:2
`define CPWM_MODE_PWM_HI      2'b11
`define CPWM_MODE_OFF         4'h0

// timer control fields
`define CPWM_TCTL_PRESCALE    1:0
`define CPWM_TCTL_ON          2
`define CPWM_TCTL_POSTSCALE   6:3

// pin used by the waveform within the shared port
`define CPWM_PIN_BIT          2

// reset values
`define CPWM_RST_PERIOD       8'hff
`define CPWM_RST_PORT_DIR     8'hff
`define CPWM_RST_ZERO8        8'h00

// oscillator periods per timer step before prescaling
`define CPWM_Q_PHASES         4

// bus answers
`define CPWM_RESP_OKAY        2'b00
`define CPWM_RESP_SLVERR      2'b10

`endif

// >>> verilog/cpwm_timebase.v
`timescale 1ns/1ps
`include "cpwm_defines.vh"

module cpwm_timebase (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       enable,
	input  wire [1:0] prescale_sel,
	input  wire [7:0] period_value,
	output wire [7:0] timer_value,
	output wire [1:0] phase_value,
	output wire       period_wrap
);
	reg [3:0] pre_q;
	reg [1:0] phase_q;
	reg [7:0] tmr_q;
	reg [3:0] pre_limit;
	wire      step;

	always @* begin
		case (prescale_sel)
			2'b00:   pre_limit = 4'h0;
			2'b01:   pre_limit = 4'h3;
			default: pre_limit = 4'hf;
		endcase
	end

	assign step        = enable && (pre_q >= pre_limit);
	// timer step that follows a match with the period
	assign period_wrap = step && (phase_q == 2'h3) && (tmr_q == period_value);
	assign timer_value = tmr_q;
	assign phase_value = phase_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			pre_q   <= 4'h0;
			phase_q <= 2'h0;
			tmr_q   <= 8'h00;
		end else if (enable) begin
			pre_q <= step ? 4'h0 : pre_q + 4'h1;
			if (step) begin
				phase_q <= phase_q + 2'h1;
				if (phase_q == 2'h3) begin
					if (period_wrap)
						tmr_q <= 8'h00; // R5
					else
						tmr_q <= tmr_q + 8'h01;
				end
			end
		end
	end
endmodule // cpwm_timebase

// >>> verilog/cpwm_top.v
// How it works
// R1: output waveform with up to 10-bit resolution
// R2: pin drives only while direction bit clear
// R3: control written zero forces output latch low
// R4: period is (period+1) x 4 x prescale
// R5: period match clears timer, sets pin
// R6: zero duty never sets pin
// R7: boundary copies duty into shadow and latch
// R8: postscaler never alters period, paces update flag
// R9: duty is low register plus control bits 5:4
// R10: high time is duty x osc x prescale
// R11: duty writes take effect after next match
// R12: shadow duty register ignores software writes
// R13: duty double-buffered, no mid-period glitch
// R14: pin cleared when duty equals timer and phase
// R15: duty beyond period keeps pin high
// R16: mode 0000 disables, 11xx selects waveform
// R17: duty compared every oscillator cycle
`timescale 1ns/1ps
`include "cpwm_defines.vh"

module cpwm_top #(
	parameter ADDR_W = 8
) (
	input  wire              aclk,
	input  wire              aresetn,
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire [2:0]        s_axi_awprot,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	output wire [1:0]        s_axi_bresp,
	output wire              s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire [2:0]        s_axi_arprot,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	output wire [31:0]       s_axi_rdata,
	output wire [1:0]        s_axi_rresp,
	output wire              s_axi_rvalid,
	input  wire              s_axi_rready,
	output wire              waveform_output_pin,
	output wire              waveform_output_pin_oe
);
	function mapped;
		input [5:0] idx;
		begin
			case (idx)
				`CPWM_IDX_PORT_DATA, `CPWM_IDX_TIMER, `CPWM_IDX_TIMER_CTRL,
				`CPWM_IDX_PERIOD, `CPWM_IDX_PORT_DIR, `CPWM_IDX_DUTY_WRITE,
				`CPWM_IDX_DUTY_SHADOW, `CPWM_IDX_UNIT_CTRL, `CPWM_IDX_STATUS,
				`CPWM_IDX_UNIT2_CTRL: mapped = 1'b1;
				default:              mapped = 1'b0;
			endcase
		end
	endfunction

	// bus state
	reg              awready_q;
	reg              wready_q;
	reg              aw_full_q;
	reg              w_full_q;
	reg [5:0]        wr_idx_q;
	reg [7:0]        wr_data_q;
	reg              wr_strb_q;
	reg              bvalid_q;
	reg [1:0]        bresp_q;
	reg              arready_q;
	reg              rvalid_q;
	reg [31:0]       rdata_q;
	reg [1:0]        rresp_q;

	// software registers
	reg [5:0]        ctrl_q;
	reg [5:0]        ctrl2_q;
	reg [7:0]        duty_write_q;
	reg [7:0]        duty_shadow_q;
	reg [1:0]        duty_lsb_latch_q;
	reg [7:0]        period_q;
	reg [6:0]        tctl_q;
	reg [7:0]        port_dir_q;
	reg [7:0]        port_data_q;
	reg [3:0]        post_cnt_q;
	reg              update_flag_q;
	reg              wave_latch_q;
	reg              pin_q;
	reg              pin_oe_q;
	reg              wrap_q;

	wire             aw_take;
	wire             w_take;
	wire             do_wr;
	wire             aw_full_d;
	wire             w_full_d;
	wire             bvalid_d;
	wire             ar_take;
	wire             rvalid_d;
	wire [5:0]       ar_idx;
	wire             pwm_mode;
	wire [7:0]       tmr;
	wire [1:0]       phase;
	wire             wrap;
	wire [9:0]       duty_new;
	wire             wr_ctrl;
	wire             clr_update;
	reg  [7:0]       rd_val;

	assign aw_take   = s_axi_awvalid && awready_q;
	assign w_take    = s_axi_wvalid && wready_q;
	assign do_wr     = aw_full_q && w_full_q && !bvalid_q;
	assign aw_full_d = (aw_full_q || aw_take) && !do_wr;
	assign w_full_d  = (w_full_q || w_take) && !do_wr;
	assign bvalid_d  = (bvalid_q && !s_axi_bready) || do_wr;
	assign ar_take   = s_axi_arvalid && arready_q;
	assign rvalid_d  = (rvalid_q && !s_axi_rready) || ar_take;
	assign ar_idx    = s_axi_araddr[7:2];

	assign wr_ctrl    = do_wr && wr_strb_q && (wr_idx_q == `CPWM_IDX_UNIT_CTRL);
	assign clr_update = do_wr && wr_strb_q && (wr_idx_q == `CPWM_IDX_STATUS) && wr_data_q[1];

	assign pwm_mode = (ctrl_q[`CPWM_CTRL_PWM_BITS] == `CPWM_MODE_PWM_HI); // R16
	assign duty_new = {duty_write_q, ctrl_q[`CPWM_CTRL_DUTY_LSB]}; // R9

	cpwm_timebase u_timebase (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.enable       (tctl_q[`CPWM_TCTL_ON]),
		.prescale_sel (tctl_q[`CPWM_TCTL_PRESCALE]),
		.period_value (period_q), // R4
		.timer_value  (tmr),
		.phase_value  (phase),
		.period_wrap  (wrap)
	);

	// write channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			wr_idx_q  <= 6'h00;
			wr_data_q <= 8'h00;
			wr_strb_q <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `CPWM_RESP_OKAY;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q  <= w_full_d;
			awready_q <= !aw_full_d && !bvalid_d;
			wready_q  <= !w_full_d && !bvalid_d;
			bvalid_q  <= bvalid_d;
			if (aw_take)
				wr_idx_q <= s_axi_awaddr[7:2];
			if (w_take) begin
				wr_data_q <= s_axi_wdata[7:0];
				wr_strb_q <= s_axi_wstrb[0];
			end
			if (do_wr)
				bresp_q <= mapped(wr_idx_q) ? `CPWM_RESP_OKAY : `CPWM_RESP_SLVERR;
		end
	end

	// read channel
	always @* begin
		case (ar_idx)
			`CPWM_IDX_PORT_DATA:   rd_val = port_data_q;
			`CPWM_IDX_TIMER:       rd_val = tmr;
			`CPWM_IDX_TIMER_CTRL:  rd_val = {1'b0, tctl_q};
			`CPWM_IDX_PERIOD:      rd_val = period_q;
			`CPWM_IDX_PORT_DIR:    rd_val = port_dir_q;
			`CPWM_IDX_DUTY_WRITE:  rd_val = duty_write_q;
			`CPWM_IDX_DUTY_SHADOW: rd_val = duty_shadow_q;
			`CPWM_IDX_UNIT_CTRL:   rd_val = {2'b00, ctrl_q};
			`CPWM_IDX_STATUS:      rd_val = {6'h00, update_flag_q, wave_latch_q};
			`CPWM_IDX_UNIT2_CTRL:  rd_val = {2'b00, ctrl2_q};
			default:               rd_val = 8'h00;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= `CPWM_RESP_OKAY;
		end else begin
			rvalid_q  <= rvalid_d;
			arready_q <= !rvalid_d;
			if (ar_take) begin
				rdata_q <= {24'h000000, rd_val};
				rresp_q <= mapped(ar_idx) ? `CPWM_RESP_OKAY : `CPWM_RESP_SLVERR;
			end
		end
	end

	// register writes; duty writes land in the write register at any time
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q       <= 6'h00;
			ctrl2_q      <= 6'h00;
			duty_write_q <= `CPWM_RST_ZERO8;
			period_q     <= `CPWM_RST_PERIOD;
			tctl_q       <= 7'h00;
			port_dir_q   <= `CPWM_RST_PORT_DIR;
			port_data_q  <= `CPWM_RST_ZERO8;
		end else if (do_wr && wr_strb_q) begin
			case (wr_idx_q)
				`CPWM_IDX_UNIT_CTRL:   ctrl_q       <= wr_data_q[5:0];
				`CPWM_IDX_UNIT2_CTRL:  ctrl2_q      <= wr_data_q[5:0];
				`CPWM_IDX_DUTY_WRITE:  duty_write_q <= wr_data_q; // R11
				`CPWM_IDX_PERIOD:      period_q     <= wr_data_q;
				`CPWM_IDX_TIMER_CTRL:  tctl_q       <= wr_data_q[6:0];
				`CPWM_IDX_PORT_DIR:    port_dir_q   <= wr_data_q;
				`CPWM_IDX_PORT_DATA:   port_data_q  <= wr_data_q;
				`CPWM_IDX_DUTY_SHADOW: ctrl2_q      <= ctrl2_q; // R12
				default:               ctrl2_q      <= ctrl2_q;
			endcase
		end
	end

	// postscaler paces only the update flag
	always @(posedge aclk) begin
		if (!aresetn) begin
			post_cnt_q    <= 4'h0;
			update_flag_q <= 1'b0;
		end else begin
			if (wrap) begin
				if (post_cnt_q == tctl_q[`CPWM_TCTL_POSTSCALE])
					post_cnt_q <= 4'h0;
				else
					post_cnt_q <= post_cnt_q + 4'h1;
			end
			// set wins over a clear in the same cycle
			if (wrap && (post_cnt_q == tctl_q[`CPWM_TCTL_POSTSCALE]))
				update_flag_q <= 1'b1; // R8
			else if (clr_update)
				update_flag_q <= 1'b0;
		end
	end

	// wrap delayed by one clock; the latch is set here so high time is whole steps
	always @(posedge aclk) begin
		if (!aresetn)
			wrap_q <= 1'b0;
		else
			wrap_q <= wrap;
	end

	// waveform latch and double buffer
	always @(posedge aclk) begin
		if (!aresetn) begin
			duty_shadow_q    <= 8'h00;
			duty_lsb_latch_q <= 2'b00;
			wave_latch_q     <= 1'b0;
		end else if ((wr_ctrl && (wr_data_q[5:0] == 6'h00)) ||
		             (ctrl_q[`CPWM_CTRL_MODE] == `CPWM_MODE_OFF)) begin
			duty_shadow_q    <= 8'h00; // R16
			duty_lsb_latch_q <= 2'b00;
			wave_latch_q     <= 1'b0; // R3
		end else if (!pwm_mode) begin
			wave_latch_q <= 1'b0;
		end else begin
			if (wrap) begin
				duty_shadow_q    <= duty_new[9:2]; // R7 R13
				duty_lsb_latch_q <= duty_new[1:0];
			end
			// set one clock after the copy, cleared one clock after the step that reaches the duty
			if (wrap_q)
				wave_latch_q <= ({duty_shadow_q, duty_lsb_latch_q} != 10'h000); // R5 R6
			else if ({tmr, phase} == {duty_shadow_q, duty_lsb_latch_q})
				wave_latch_q <= 1'b0; // R14 R17 R10 R15 R1
		end
	end

	// shared pin: waveform in the right mode, port latch otherwise
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_q    <= 1'b0;
			pin_oe_q <= 1'b0;
		end else begin
			pin_q    <= pwm_mode ? wave_latch_q : port_data_q[`CPWM_PIN_BIT];
			pin_oe_q <= !port_dir_q[`CPWM_PIN_BIT]; // R2
		end
	end

	assign s_axi_awready          = awready_q;
	assign s_axi_wready           = wready_q;
	assign s_axi_bvalid           = bvalid_q;
	assign s_axi_bresp            = bresp_q;
	assign s_axi_arready          = arready_q;
	assign s_axi_rvalid           = rvalid_q;
	assign s_axi_rdata            = rdata_q;
	assign s_axi_rresp            = rresp_q;
	assign waveform_output_pin    = pin_q;
	assign waveform_output_pin_oe = pin_oe_q;
endmodule // cpwm_top

// >>> dv/cpwm_assertions.sv
`timescale 1ns/1ps
module cpwm_checker (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic        waveform_output_pin
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read upper bits set");
	a_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while busy");
	a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	a_pin_space: assert property ($rose(waveform_output_pin) |=> !$rose(waveform_output_pin) [*3])
		else $error("pin period too short");
endmodule // cpwm_checker

// >>> dv/cpwm_load.sv
`timescale 1ns/1ps
module cpwm_load (
	input  logic        aclk,
	input  logic        pin,
	input  logic        drive_en,
	output logic [15:0] high_len = 16'h0,
	output logic [15:0] period_len = 16'h0,
	output logic [15:0] rise_cnt = 16'h0
);
	logic        prev_q = 1'h0;
	logic [15:0] cnt_q = 16'h0;
	// load only sees the level while the pin is driven
	always @(posedge aclk) begin
		prev_q <= pin && drive_en;
		cnt_q  <= cnt_q + 16'h1;
		if (pin && drive_en && !prev_q) begin
			period_len <= cnt_q;
			rise_cnt   <= rise_cnt + 16'h1;
			cnt_q      <= 16'h1;
		end
		if (!pin && prev_q)
			high_len <= cnt_q;
	end
endmodule // cpwm_load

// >>> dv/test_ccp_pwm_generator.sv
`timescale 1ns/1ps
`include "cpwm_defines.vh"
module test_ccp_pwm_generator;
	logic        aclk = 1'h0, aresetn = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h1;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         waveform_output_pin, waveform_output_pin_oe;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [15:0]  high_len, period_len, rise_cnt;
	logic [15:0] r0;
	integer      failures = 0, num_checks = 0;
	always #25 aclk = ~aclk;
	cpwm_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .waveform_output_pin, .waveform_output_pin_oe);
	cpwm_load u_load (.aclk, .pin(waveform_output_pin), .drive_en(waveform_output_pin_oe),
		.high_len, .period_len, .rise_cnt);
	task end_sim;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task tmo(input integer n);
		if (n >= 50) begin
			failures++;
			end_sim;
		end
	endtask
	task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] e);
		integer n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr  <= {i, 2'h0};
		s_axi_wdata   <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'h0;
		tmo(n);
		chk(s_axi_bresp, e);
	endtask
	task automatic rd(input logic [5:0] i, input logic [7:0] d, input logic [1:0] e);
		integer n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr  <= {i, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid && n < 50);
		s_axi_rready <= 1'h0;
		tmo(n);
		chk(s_axi_rresp, e);
		if (e == 2'h0) chk(s_axi_rdata, {24'h0, d});
	endtask
	// program duty, let wt clocks (over three periods) pass, measure the load
	task run(input logic [7:0] hi8, ctl, input logic [15:0] eh, ep, input integer wt);
		wr(`CPWM_IDX_DUTY_WRITE, hi8, 2'h0);
		wr(`CPWM_IDX_UNIT_CTRL, ctl, 2'h0);
		repeat (wt) @(posedge aclk);
		chk(high_len, eh);
		chk(period_len, ep);
	endtask
	task quiet(input logic lvl);
		repeat (40) @(posedge aclk);
		r0 = rise_cnt;
		repeat (40) @(posedge aclk);
		chk(rise_cnt, r0);
		chk(waveform_output_pin, lvl);
	endtask
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		rd(`CPWM_IDX_PERIOD, 8'hff, 2'h0);
		rd(`CPWM_IDX_PORT_DIR, 8'hff, 2'h0);
		chk(waveform_output_pin_oe, 32'h0);
		rd(6'h3f, 8'h00, 2'h2);
		wr(6'h3f, 8'h00, 2'h2);
		wr(`CPWM_IDX_TIMER_CTRL, 8'h04, 2'h0);
		wr(`CPWM_IDX_PERIOD, 8'h03, 2'h0);
		wr(`CPWM_IDX_PORT_DIR, 8'hfb, 2'h0);
		run(8'h02, 8'h1c, 16'd9, 16'd16, 50);
		chk(waveform_output_pin_oe, 32'h1);
		rd(`CPWM_IDX_DUTY_SHADOW, 8'h02, 2'h0);
		wr(`CPWM_IDX_DUTY_SHADOW, 8'h55, 2'h0);
		rd(`CPWM_IDX_DUTY_SHADOW, 8'h02, 2'h0);
		run(8'h03, 8'h1c, 16'd13, 16'd16, 50);
		wr(`CPWM_IDX_DUTY_WRITE, 8'hff, 2'h0);
		quiet(1'h1);
		wr(`CPWM_IDX_DUTY_WRITE, 8'h00, 2'h0);
		wr(`CPWM_IDX_UNIT_CTRL, 8'h0c, 2'h0);
		quiet(1'h0);
		run(8'h02, 8'h1c, 16'd9, 16'd16, 50);
		wr(`CPWM_IDX_UNIT_CTRL, 8'h00, 2'h0);
		repeat (2) @(posedge aclk);
		chk(waveform_output_pin, 32'h0);
		rd(`CPWM_IDX_DUTY_SHADOW, 8'h00, 2'h0);
		rd(`CPWM_IDX_STATUS, 8'h02, 2'h0);
		wr(`CPWM_IDX_PORT_DATA, 8'h04, 2'h0);
		wr(`CPWM_IDX_UNIT_CTRL, 8'h08, 2'h0);
		repeat (2) @(posedge aclk);
		chk(waveform_output_pin, 32'h1);
		wr(`CPWM_IDX_TIMER_CTRL, 8'h7d, 2'h0);
		wr(`CPWM_IDX_STATUS, 8'h02, 2'h0);
		rd(`CPWM_IDX_STATUS, 8'h00, 2'h0);
		run(8'h02, 8'h1f, 16'd36, 16'd64, 200);
		end_sim;
	end
endmodule // test_ccp_pwm_generator
bind cpwm_top cpwm_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .waveform_output_pin);
